// *** shared/dsa_consts.vh ***
// Register offsets, field positions, codes and reset values of the decimal string unit.
`ifndef DSA_CONSTS_VH
`define DSA_CONSTS_VH
`define DSA_OFF_CTRL 12'h000
`define DSA_OFF_IADDR 12'h004
`define DSA_OFF_RESULT 12'h008
`define DSA_OFF_LENGTH 12'h00c
`define DSA_OFF_STATUS 12'h010
`define DSA_CTRL_START 0
`define DSA_CTRL_HOLD 1
`define DSA_ST_BUSY 0
`define DSA_ST_OV 1
`define DSA_ST_DONE 2
`define DSA_ST_BADOP 3
`define DSA_OPC_SUM 14'h0c40
`define DSA_OPC_DIFF 14'h0c41
`define DSA_IND_SRC 1
`define DSA_IND_DST 0
`define DSA_SIGN_POS 8'h00
`define DSA_SIGN_NEG 8'hff
`define DSA_SCR_BUSY 8'h01
`define DSA_SCR_IDLE 8'h00
`define DSA_RES_POS 16'h0001
`define DSA_RES_NEG 16'hffff
`define DSA_RES_ZERO 16'h0000
`define DSA_RST_WORD 16'h0000
`endif

// *** rtl/dsa_unit.v ***
// Decimal string add and subtract engine with an APB register file and a byte memory port.
//
// Behaviour
// - An instruction is three words: opcode, source address, destination address.
// - First parameter word is the source address, second the destination address.
// - Each operand follows at most one level of indirection.
// - Every effective operand address is a byte address.
// - Each byte holds a zone and a digit; the digit is the low nibble.
// - Source zones are ignored; results take the destination byte's zone.
// - Digits are not checked; software must supply valid digit and sign bytes.
// - Operands point at a sign byte: zero positive, all ones negative.
// - Digits run from most significant at low to least significant at high addresses.
// - The byte just before the destination sign is used as a scratch cell.
// - Software clears the scratch byte first; the engine leaves it zero.
// - String length including sign comes from the low five length bits.
// - Execution can be paused and resumed; progress state must be kept.
// - Length stays unchanged; result shows positive, zero or negative.
// - Overflow flag is set on decimal overflow and cleared otherwise.
// - Length zero or one does nothing to memory or flags except setting the done bit.
// - The sum operation adds source to destination, result replaces destination.
// - The difference operation subtracts source from destination into destination.
`timescale 1ns/1ps
`include "dsa_consts.vh"

module dsa_unit (
	// Clock and reset.
	input wire CLK_I,
	input wire RST_I,
	// APB slave.
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [11:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output reg [31:0] PRDATA_O,
	output wire PREADY_O,
	output wire PSLVERR_O,
	// Byte memory master.
	output reg MEM_REQ_O,
	output reg MEM_WE_O,
	output reg [15:0] MEM_ADDR_O,
	output reg [7:0] MEM_WDATA_O,
	input wire [7:0] MEM_RDATA_I,
	input wire MEM_ACK_I
);

	localparam [3:0] S_IDLE = 4'h0, S_FETCH = 4'h1, S_IND = 4'h2, S_RDSRC = 4'h3;
	localparam [3:0] S_RDDST = 4'h4, S_SCR1 = 4'h5, S_CALC = 4'h6, S_FIX = 4'h7;
	localparam [3:0] S_WRDST = 4'h8, S_SCR0 = 4'h9, S_FIN = 4'ha;

	reg [3:0] state;
	reg [4:0] cnt;
	reg hold, ov, done, badop, ind_dst, is_diff, src_neg, res_neg, carry;
	reg [15:0] iaddr, result, length, word0, src_ea, dst_ea;
	reg [7:0] hi_byte;
	reg [3:0] src_dig [0:31];
	reg [7:0] dst_byte [0:31];
	reg [3:0] res_dig [0:31];

	wire [4:0] len, last;
	wire busy, is_mem, acked, apb_setup, apb_wr, mapped, dst_neg, eff_src_neg, same;
	wire [13:0] opc;
	wire [15:0] ptr;

	reg [15:0] cur_addr;
	reg [7:0] cur_wdata;
	reg [31:0] rd_mux;
	reg [4:0] t;
	reg [3:0] x, y, dig;
	reg cur_we, co, nz;
	integer i;

	assign len = length[4:0];
	assign last = len - 5'h01;
	assign busy = (state != S_IDLE);
	assign is_mem = (state == S_FETCH) || (state == S_IND) || (state == S_RDSRC) ||
		(state == S_RDDST) || (state == S_SCR1) || (state == S_WRDST) || (state == S_SCR0);
	assign acked = is_mem && MEM_REQ_O && MEM_ACK_I;
	assign apb_setup = PSEL_I && !PENABLE_I;
	assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
	assign mapped = (PADDR_I == `DSA_OFF_CTRL) || (PADDR_I == `DSA_OFF_IADDR) ||
		(PADDR_I == `DSA_OFF_RESULT) || (PADDR_I == `DSA_OFF_LENGTH) ||
		(PADDR_I == `DSA_OFF_STATUS);
	// Zero wait states keep the bus simple; every access ends in its first access cycle.
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
	assign dst_neg = (dst_byte[0] == `DSA_SIGN_NEG);
	assign eff_src_neg = src_neg ^ is_diff;
	assign same = (eff_src_neg == dst_neg);
	assign opc = word0[15:2];
	assign ptr = ind_dst ? dst_ea : src_ea;

	// Memory request fields for the current state and byte index.
	always @* begin
		cur_addr = 16'h0000;
		cur_we = 1'b0;
		cur_wdata = `DSA_SCR_IDLE;
		case (state)
			S_FETCH: cur_addr = {iaddr[14:0], 1'b0} + {11'h000, cnt};
			S_IND: cur_addr = {ptr[14:0], 1'b0} + {11'h000, cnt};
			S_RDSRC: cur_addr = src_ea + {11'h000, cnt};
			S_RDDST: cur_addr = dst_ea + {11'h000, cnt};
			S_SCR1: begin
				cur_addr = dst_ea - 16'h0001;
				cur_we = 1'b1;
				cur_wdata = `DSA_SCR_BUSY;
			end
			S_WRDST: begin
				cur_addr = dst_ea + {11'h000, cnt};
				cur_we = 1'b1;
				if (cnt == 5'h00) begin
					cur_wdata = (res_neg && nz) ? `DSA_SIGN_NEG : `DSA_SIGN_POS;
				end else begin
					cur_wdata = {dst_byte[cnt][7:4], res_dig[cnt]};
				end
			end
			S_SCR0: begin
				cur_addr = dst_ea - 16'h0001;
				cur_we = 1'b1;
				cur_wdata = `DSA_SCR_IDLE;
			end
			default: cur_addr = 16'h0000;
		endcase
	end

	// One decimal digit step; invalid nibbles are passed through the same arithmetic.
	always @* begin
		x = (state == S_FIX) ? 4'h0 : dst_byte[cnt][3:0];
		y = (state == S_FIX) ? res_dig[cnt] : src_dig[cnt];
		t = 5'h00;
		dig = 4'h0;
		co = 1'b0;
		if ((state == S_CALC) && same) begin
			t = {1'b0, x} + {1'b0, y} + {4'h0, carry};
			co = (t > 5'h09);
			dig = co ? (t[3:0] - 4'ha) : t[3:0];
		end else begin
			t = {1'b0, x} - {1'b0, y} - {4'h0, carry};
			co = t[4];
			dig = co ? (t[3:0] + 4'ha) : t[3:0];
		end
	end

	// Nonzero test over the result digits that belong to the string.
	always @* begin
		nz = 1'b0;
		for (i = 1; i < 32; i = i + 1) begin
			if ((i < len) && (res_dig[i] != 4'h0)) nz = 1'b1;
		end
	end

	always @* begin
		case (PADDR_I)
			`DSA_OFF_CTRL: rd_mux = {30'h00000000, hold, 1'b0};
			`DSA_OFF_IADDR: rd_mux = {16'h0000, iaddr};
			`DSA_OFF_RESULT: rd_mux = {16'h0000, result};
			`DSA_OFF_LENGTH: rd_mux = {16'h0000, length};
			`DSA_OFF_STATUS: rd_mux = {28'h0000000, badop, done, ov, busy};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge CLK_I) begin
		if (RST_I) begin
			state <= S_IDLE;
			cnt <= 5'h00;
			hold <= 1'b0;
			iaddr <= `DSA_RST_WORD;
			result <= `DSA_RST_WORD;
			length <= `DSA_RST_WORD;
			ov <= 1'b0;
			done <= 1'b0;
			badop <= 1'b0;
			word0 <= `DSA_RST_WORD;
			src_ea <= `DSA_RST_WORD;
			dst_ea <= `DSA_RST_WORD;
			hi_byte <= 8'h00;
			ind_dst <= 1'b0;
			is_diff <= 1'b0;
			src_neg <= 1'b0;
			res_neg <= 1'b0;
			carry <= 1'b0;
			PRDATA_O <= 32'h00000000;
			MEM_REQ_O <= 1'b0;
			MEM_WE_O <= 1'b0;
			MEM_ADDR_O <= 16'h0000;
			MEM_WDATA_O <= 8'h00;
		end else begin
			if (apb_setup) PRDATA_O <= rd_mux;
			if (apb_wr) begin
				case (PADDR_I)
					`DSA_OFF_CTRL: begin
						hold <= PWDATA_I[`DSA_CTRL_HOLD];
						if (PWDATA_I[`DSA_CTRL_START] && !busy) begin
							if (len < 5'h02) done <= 1'b1;
							else begin
								state <= S_FETCH;
								cnt <= 5'h00;
								done <= 1'b0;
								badop <= 1'b0;
							end
						end
					end
					`DSA_OFF_IADDR: if (!busy) iaddr <= PWDATA_I[15:0];
					`DSA_OFF_RESULT: if (!busy) result <= PWDATA_I[15:0];
					`DSA_OFF_LENGTH: if (!busy) length <= PWDATA_I[15:0];
					`DSA_OFF_STATUS: if (!busy) ov <= PWDATA_I[`DSA_ST_OV];
					default: hold <= hold;
				endcase
			end
			// A paused engine finishes the access in flight and issues no new one.
			if (is_mem && !MEM_REQ_O && !hold) begin
				MEM_REQ_O <= 1'b1;
				MEM_ADDR_O <= cur_addr;
				MEM_WE_O <= cur_we;
				MEM_WDATA_O <= cur_wdata;
			end else if (acked) begin
				MEM_REQ_O <= 1'b0;
				MEM_WE_O <= 1'b0;
			end
			case (state)
				// A start written this cycle must survive; the default branch would undo it.
				S_IDLE: carry <= 1'b0;
				S_FETCH: if (acked) begin
					case (cnt[2:0])
						3'h0: word0[15:8] <= MEM_RDATA_I;
						3'h1: word0[7:0] <= MEM_RDATA_I;
						3'h2: src_ea[15:8] <= MEM_RDATA_I;
						3'h3: src_ea[7:0] <= MEM_RDATA_I;
						3'h4: dst_ea[15:8] <= MEM_RDATA_I;
						default: dst_ea[7:0] <= MEM_RDATA_I;
					endcase
					cnt <= cnt + 5'h01;
					if (cnt == 5'h05) begin
						cnt <= 5'h00;
						is_diff <= (opc == `DSA_OPC_DIFF);
						if ((opc != `DSA_OPC_SUM) && (opc != `DSA_OPC_DIFF)) begin
							badop <= 1'b1;
							done <= 1'b1;
							state <= S_IDLE;
						end else if (word0[`DSA_IND_SRC]) begin
							ind_dst <= 1'b0;
							state <= S_IND;
						end else if (word0[`DSA_IND_DST]) begin
							ind_dst <= 1'b1;
							state <= S_IND;
						end else begin
							state <= S_RDSRC;
						end
					end
				end
				S_IND: if (acked) begin
					if (cnt == 5'h00) begin
						hi_byte <= MEM_RDATA_I;
						cnt <= 5'h01;
					end else begin
						// The fetched word is final; it is never dereferenced again.
						if (ind_dst) dst_ea <= {hi_byte, MEM_RDATA_I};
						else src_ea <= {hi_byte, MEM_RDATA_I};
						cnt <= 5'h00;
						if (!ind_dst && word0[`DSA_IND_DST]) ind_dst <= 1'b1;
						else state <= S_RDSRC;
					end
				end
				S_RDSRC: if (acked) begin
					src_dig[cnt] <= MEM_RDATA_I[3:0];
					if (cnt == 5'h00) src_neg <= (MEM_RDATA_I == `DSA_SIGN_NEG);
					cnt <= cnt + 5'h01;
					if (cnt == last) begin
						cnt <= 5'h00;
						state <= S_RDDST;
					end
				end
				S_RDDST: if (acked) begin
					dst_byte[cnt] <= MEM_RDATA_I;
					cnt <= cnt + 5'h01;
					if (cnt == last) begin
						cnt <= 5'h00;
						state <= S_SCR1;
					end
				end
				S_SCR1: if (acked) begin
					cnt <= last;
					carry <= 1'b0;
					state <= S_CALC;
				end
				S_CALC: begin
					res_dig[cnt] <= dig;
					carry <= co;
					cnt <= cnt - 5'h01;
					if (cnt == 5'h01) begin
						cnt <= 5'h00;
						state <= S_WRDST;
						res_neg <= dst_neg;
						if (same) ov <= co;
						else begin
							ov <= 1'b0;
							if (co) begin
								// Magnitude went negative: take the ten's complement.
								res_neg <= eff_src_neg;
								cnt <= last;
								carry <= 1'b0;
								state <= S_FIX;
							end
						end
					end
				end
				S_FIX: begin
					res_dig[cnt] <= dig;
					carry <= co;
					cnt <= cnt - 5'h01;
					if (cnt == 5'h01) begin
						cnt <= 5'h00;
						state <= S_WRDST;
					end
				end
				S_WRDST: if (acked) begin
					cnt <= cnt + 5'h01;
					if (cnt == last) begin
						cnt <= 5'h00;
						state <= S_SCR0;
					end
				end
				S_SCR0: if (acked) state <= S_FIN;
				S_FIN: begin
					// Length is never written here, so it reads back as entered.
					result <= nz ? (res_neg ? `DSA_RES_NEG : `DSA_RES_POS) : `DSA_RES_ZERO;
					done <= 1'b1;
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

endmodule // dsa_unit

// *** verification/dsa_mem.sv ***
// Byte memory partner that answers each engine request after a set delay.
`timescale 1ns/1ps
module dsa_mem (
	input wire clk,
	input wire req,
	input wire we,
	input wire [15:0] addr,
	input wire [7:0] wdata,
	input wire [3:0] lat,
	output reg [7:0] rdata,
	output reg ack
);
	reg [7:0] m [0:65535];
	reg [3:0] cnt = 4'h0;
	initial begin
		ack = 1'b0;
		rdata = 8'h5a;
	end
	always @(posedge clk) begin
		ack <= 1'b0;
		// Read data toggles outside the ack cycle so a late sample never looks valid.
		rdata <= ~rdata;
		if (req && !ack) begin
			cnt <= cnt + 4'h1;
			if (cnt >= lat) begin
				cnt <= 4'h0;
				ack <= 1'b1;
				if (we) m[addr] <= wdata;
				else rdata <= m[addr];
			end
		end
	end
endmodule // dsa_mem

// *** verification/dsa_unit_checker.sv ***
// Port checker for the decimal string unit, bound to its top module.
`timescale 1ns/1ps
module dsa_unit_checker (
	// Clock and reset.
	input wire CLK_I,
	input wire RST_I,
	// APB.
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [11:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	input wire [31:0] PRDATA_O,
	input wire PREADY_O,
	input wire PSLVERR_O,
	// Memory.
	input wire MEM_REQ_O,
	input wire MEM_WE_O,
	input wire [15:0] MEM_ADDR_O,
	input wire [7:0] MEM_WDATA_O,
	input wire [7:0] MEM_RDATA_I,
	input wire MEM_ACK_I
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	wire wr = PSEL_I && PENABLE_I && PWRITE_I;
	wire rd = PSEL_I && PENABLE_I && !PWRITE_I;
	wire go = wr && PADDR_I == 12'h000 && PWDATA_I[0];
	// Length and address shadows stay exact only because the bench writes them while idle.
	reg [15:0] len_t;
	reg [15:0] ia_t;
	reg hold_t;
	always @(posedge CLK_I) begin
		if (RST_I) begin
			len_t <= 16'h0;
			ia_t <= 16'h0;
			hold_t <= 1'b0;
		end else if (wr) begin
			if (PADDR_I == 12'h00c) len_t <= PWDATA_I[15:0];
			if (PADDR_I == 12'h004) ia_t <= PWDATA_I[15:0];
			if (PADDR_I == 12'h000) hold_t <= PWDATA_I[1];
		end
	end
	property p_hold;
		MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O) && $stable(MEM_WE_O);
	endproperty
	a_hold: assert property (p_hold) else $error("request moved");
	property p_gap;
		MEM_ACK_I |=> !MEM_REQ_O;
	endproperty
	a_gap: assert property (p_gap) else $error("no gap");
	property p_pause;
		hold_t && !MEM_REQ_O |=> !MEM_REQ_O;
	endproperty
	a_pause: assert property (p_pause) else $error("request in pause");
	property p_nop;
		go && len_t[4:0] < 5'h2 && !MEM_REQ_O |=> !MEM_REQ_O [*8];
	endproperty
	a_nop: assert property (p_nop) else $error("nop touched memory");
	property p_first;
		go && len_t[4:0] > 5'h1 && !hold_t |-> ##[1:8] MEM_REQ_O && !MEM_WE_O
			&& MEM_ADDR_O == {ia_t[14:0], 1'b0};
	endproperty
	a_first: assert property (p_first) else $error("opcode not read");
	property p_next;
		MEM_ACK_I && !MEM_WE_O && !hold_t && MEM_ADDR_O == {ia_t[14:0], 1'b0}
			|-> ##2 MEM_REQ_O && MEM_ADDR_O == {ia_t[14:0], 1'b1};
	endproperty
	a_next: assert property (p_next) else $error("opcode low byte");
	property p_len;
		rd && PADDR_I == 12'h00c |-> PRDATA_O == {16'h0, len_t};
	endproperty
	a_len: assert property (p_len) else $error("length changed");
	property p_ctrl;
		rd && PADDR_I == 12'h000 |-> PRDATA_O == {30'h0, hold_t, 1'b0};
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control readback");
	cover property (go && len_t[4:0] > 5'h1);
	cover property (hold_t && MEM_REQ_O);
	cover property (MEM_REQ_O && MEM_WE_O && MEM_WDATA_O == 8'h01);
endmodule // dsa_unit_checker
bind dsa_unit dsa_unit_checker dsa_unit_checker_i (.CLK_I(CLK_I), .RST_I(RST_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.MEM_REQ_O(MEM_REQ_O), .MEM_WE_O(MEM_WE_O), .MEM_ADDR_O(MEM_ADDR_O),
	.MEM_WDATA_O(MEM_WDATA_O), .MEM_RDATA_I(MEM_RDATA_I), .MEM_ACK_I(MEM_ACK_I));

// *** verification/dsa_unit_tb.sv ***
// Self-checking bench for the decimal string unit.
`timescale 1ns/1ps
`include "dsa_consts.vh"
module dsa_unit_tb;
	reg clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
	reg [11:0] paddr = 12'h0;
	reg [31:0] pwdata = 32'h0, rd;
	reg [3:0] lat = 4'h0;
	wire [31:0] prdata;
	wire pready, pslverr, mreq, mwe, mack;
	wire [15:0] maddr;
	wire [7:0] mwd, mrd;
	integer seed = 32'h68bd7ec8, n_mismatch = 0, comparisons = 0, i, k;
	dsa_unit dsa_unit_i (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .MEM_REQ_O(mreq), .MEM_WE_O(mwe),
		.MEM_ADDR_O(maddr), .MEM_WDATA_O(mwd), .MEM_RDATA_I(mrd), .MEM_ACK_I(mack));
	dsa_mem dsa_mem_i (.clk(clk), .req(mreq), .we(mwe), .addr(maddr), .wdata(mwd),
		.lat(lat), .rdata(mrd), .ack(mack));
	initial forever #4 clk = ~clk;
	task give_verdict;
		begin
			if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
			else $display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		begin
			comparisons++;
			if (g !== e) begin
				n_mismatch++;
				$display("mismatch %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwr <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			pen <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1) @(posedge clk);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask
	task put16(input [15:0] a, input [15:0] v);
		begin
			dsa_mem_i.m[a] = v[15:8];
			dsa_mem_i.m[a + 16'h1] = v[7:0];
		end
	endtask
	task run(input integer op, input integer ind, input integer l, input integer md);
		longint a, b, r, p;
		integer sa, sb, j, sg, ovp, ovx, resx, len16;
		reg [7:0] ex [0:31];
		begin
			lat <= (md == 3) ? 4'h0 : 4'($random(seed));
			a = 0;
			b = 0;
			p = 1;
			sa = (md == 1) ? 0 : $random(seed) & 1;
			sb = (md == 0) ? $random(seed) & 1 : sa;
			if (md == 1 || md == 2) op = md - 1;
			ovp = $random(seed) & 1;
			len16 = ($random(seed) & 32'hffe0) | l;
			put16(16'h0200, {(op ? `DSA_OPC_DIFF : `DSA_OPC_SUM), 2'(ind)});
			put16(16'h0202, ind[1] ? 16'h0180 : 16'h0401);
			put16(16'h0204, ind[0] ? 16'h0181 : 16'h0501);
			put16(16'h0300, 16'h0401);
			put16(16'h0302, 16'h0501);
			dsa_mem_i.m[16'h0500] = 8'h00;
			dsa_mem_i.m[16'h0401] = sa ? 8'hff : 8'h00;
			ex[0] = sb ? 8'hff : 8'h00;
			dsa_mem_i.m[16'h0501] = ex[0];
			for (j = 1; j < l; j++) begin
				k = (md == 1) ? 9 : $unsigned($random(seed)) % 10;
				a = a * 10 + k;
				dsa_mem_i.m[16'h0401 + j] = 8'(($random(seed) << 4) | k);
				if (md != 2) k = $unsigned($random(seed)) % 10;
				b = b * 10 + k;
				p = p * 10;
				ex[j] = 8'(($random(seed) << 4) | k);
				dsa_mem_i.m[16'h0501 + j] = ex[j];
			end
			ovx = ovp;
			resx = 0;
			if (l > 1) begin
				if (op) sa = 1 - sa;
				sg = sb;
				ovx = 0;
				r = b - a;
				if (sa == sb) begin
					r = a + b;
					ovx = r >= p;
					r = r % p;
				end else if (a > b) begin
					r = a - b;
					sg = sa;
				end
				if (r == 0) sg = 0;
				resx = (r == 0) ? 0 : sg ? 32'hffff : 1;
				ex[0] = sg ? 8'hff : 8'h00;
				for (j = l - 1; j > 0; j--) begin
					ex[j] = {ex[j][7:4], 4'(r % 10)};
					r = r / 10;
				end
			end
			apb(1, `DSA_OFF_STATUS, ovp << 1);
			apb(1, `DSA_OFF_LENGTH, len16);
			apb(1, `DSA_OFF_RESULT, 0);
			apb(1, `DSA_OFF_IADDR, 32'h0100);
			apb(1, `DSA_OFF_CTRL, 1);
			if (md == 3) begin
				// Pause the run after 40 cycles, check the hold bit reads back, then resume after 30 more.
				repeat (40) @(posedge clk);
				apb(1, `DSA_OFF_CTRL, 2);
				apb(0, `DSA_OFF_CTRL, 0);
				chk("hold", 2, rd);
				repeat (30) @(posedge clk);
				apb(1, `DSA_OFF_CTRL, 0);
			end
			rd = 0;
			for (k = 0; k < 3000 && rd[2] !== 1'b1; k++) apb(0, `DSA_OFF_STATUS, 0);
			chk("done", 1, rd[2]);
			chk("overflow", ovx, rd[1]);
			apb(0, `DSA_OFF_RESULT, 0);
			chk("result", resx, rd);
			apb(0, `DSA_OFF_LENGTH, 0);
			chk("length", len16, rd);
			chk("scratch", 0, dsa_mem_i.m[16'h0500]);
			for (j = 0; j < l; j++) chk("dest", ex[j], dsa_mem_i.m[16'h0501 + j]);
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		apb(0, 12'h014, 0);
		chk("slverr", 1, err);
		chk("unmapped", 0, rd);
		for (i = 0; i < 14; i++) begin
			k = (i < 3) ? i : 2 + $unsigned($random(seed)) % 16;
			run(i % 2, (i / 2) % 4, k, (i > 2 && i < 6) ? i - 2 : 0);
		end
		// An undefined opcode ends with the error bit set and the destination untouched.
		dsa_mem_i.m[16'h0200] = 8'h00;
		dsa_mem_i.m[16'h0501] = 8'h5a;
		apb(1, `DSA_OFF_LENGTH, 4);
		apb(1, `DSA_OFF_CTRL, 1);
		rd = 0;
		for (k = 0; k < 100 && rd[2] !== 1'b1; k++) apb(0, `DSA_OFF_STATUS, 0);
		chk("badop", 32'hc, rd & 32'hd);
		chk("dest", 8'h5a, dsa_mem_i.m[16'h0501]);
		give_verdict;
	end
	initial begin
		#480000;
		n_mismatch++;
		give_verdict;
	end
endmodule // dsa_unit_tb
